// ### inc/ppnvm_regs.vh
// ppnvm_regs.vh: command codes, action codes, selectors and timing counts
// assumes inclusion by the parallel programming port files only
`ifndef PPNVM_REGS_VH
`define PPNVM_REGS_VH

// ****************************************
// command byte codes
// ****************************************
`define PPNVM_CMD_NOP 8'h00
`define PPNVM_CMD_ERASE 8'h80
`define PPNVM_CMD_WR_FUSE 8'h40
`define PPNVM_CMD_WR_LOCK 8'h20
`define PPNVM_CMD_WR_FLASH 8'h10
`define PPNVM_CMD_WR_EEP 8'h11
`define PPNVM_CMD_RD_SIG 8'h08
`define PPNVM_CMD_RD_FUSE 8'h04
`define PPNVM_CMD_RD_FLASH 8'h02
`define PPNVM_CMD_RD_EEP 8'h03

// ****************************************
// action select codes {hi, lo}
// ****************************************
`define PPNVM_ACT_ADDR 2'h0
`define PPNVM_ACT_DATA 2'h1
`define PPNVM_ACT_CMD 2'h2
`define PPNVM_ACT_IDLE 2'h3

// ****************************************
// fuse and lock reset values, read selectors
// ****************************************
`define PPNVM_FUSE_RST 8'hff
`define PPNVM_LOCK_RST 8'hff
`define PPNVM_SEL_FLO 2'h0
`define PPNVM_SEL_LOCK 2'h1
`define PPNVM_SEL_EXT 2'h2
`define PPNVM_SEL_FHI 2'h3
`define PPNVM_SIG_LAST 8'h02

// ****************************************
// self-timed operation lengths
// ****************************************
`define PPNVM_CLK_NS 10
`define PPNVM_WRITE_NS 1000
`define PPNVM_WRITE_CYC (`PPNVM_WRITE_NS / `PPNVM_CLK_NS)

`endif

// ### core/ppnvm_edge.v
// ppnvm_edge.v: edge detector for programmer strobes
// assumes strobes are synchronous to sys_clk
`timescale 1ns/10ps

module ppnvm_edge
(
	input wire sys_clk, // system clock
	input wire rstn, // async reset, active low
	input wire sig_in, // strobe level
	output reg rise_q, // one-cycle pulse on rising edge
	output reg fall_q // one-cycle pulse on falling edge
);

reg last_q;

// ****************************************
// edge capture
// ****************************************
// remember last level; idle level taken as low for rise detection
always @(posedge sys_clk or negedge rstn)
begin
	if (!rstn)
	begin
		last_q <= 1'b0;
		rise_q <= 1'b0;
		fall_q <= 1'b0;
	end
	else
	begin
		last_q <= sig_in;
		rise_q <= sig_in & ~last_q;
		fall_q <= ~sig_in & last_q;
	end
end

endmodule // ppnvm_edge

// ### core/ppnvm_port.v
// ppnvm_port.v: parallel programming port of the nonvolatile memories
// assumes programmer pins arrive synchronous to sys_clk; arrays are flops
`timescale 1ns/10ps
`include "ppnvm_regs.vh"

module ppnvm_port
#(
	parameter FADDR_W = 8, // flash word address bits held
	parameter EADDR_W = 6, // eeprom byte address bits held
	parameter EPAGE_W = 2, // eeprom page offset bits
	parameter WRITE_CYC = `PPNVM_WRITE_CYC, // self-timed length
	parameter [7:0] SIG0 = 8'h5a, // arbitrary signature value
	parameter [7:0] SIG1 = 8'h3c, // arbitrary signature value
	parameter [7:0] SIG2 = 8'h96, // arbitrary signature value
	parameter [7:0] CALIB = 8'h80 // arbitrary calibration value
)
(
	input wire sys_clk, // system clock
	input wire rstn, // async reset, active low
	input wire load_strobe, // load strobe, rising edge acts
	input wire action_select_hi, // action select bit 1
	input wire action_select_lo, // action select bit 0
	input wire byte_select_one, // low/high byte select
	input wire byte_select_two, // second byte select
	input wire page_load_strobe, // page latch, rising edge acts
	input wire write_n, // write pulse, active low
	input wire out_en_n, // output enable, active low
	input wire [7:0] data_in, // data bus input side
	output reg [7:0] data_out_q, // data bus output side
	output reg data_oe_q, // data bus output enable
	output reg ready_busy_q // high ready, low busy
);

localparam ST_IDLE = 2'h0;
localparam ST_BUSY = 2'h1;
localparam EDEPTH = 1 << EADDR_W;
localparam FDEPTH = 1 << FADDR_W;
localparam PDEPTH = 1 << EPAGE_W;

wire ld_rise;
wire pl_rise;
wire wr_fall;
reg [1:0] state_q;
reg [31:0] cnt_q;
reg [7:0] cmd_q;
reg [7:0] addr_lo_q;
reg [7:0] addr_hi_q;
reg [7:0] dat_lo_q;
reg [7:0] dat_hi_q;
reg [7:0] fuse_lo_q;
reg [7:0] fuse_hi_q;
reg [7:0] fuse_ext_q;
reg [7:0] lock_q;
reg [7:0] pend_q;
reg [1:0] pend_sel_q;
reg [7:0] pend_cmd_q;
reg [7:0] eep_q [0:EDEPTH-1];
reg [15:0] flash_q [0:FDEPTH-1];
reg [7:0] epbuf_q [0:PDEPTH-1];
reg [15:0] fpbuf_q [0:FDEPTH-1];
reg [PDEPTH-1:0] epvld_q;
reg [FDEPTH-1:0] fpvld_q;
reg [7:0] rd_d;
integer i;

wire [15:0] addr_w = {addr_hi_q, addr_lo_q};
wire [EADDR_W-1:0] eaddr = addr_w[EADDR_W-1:0];
wire [FADDR_W-1:0] faddr = addr_w[FADDR_W-1:0];
wire [EPAGE_W-1:0] eoff = addr_lo_q[EPAGE_W-1:0];
wire [EADDR_W-EPAGE_W-1:0] epage = eaddr[EADDR_W-1:EPAGE_W];
wire [1:0] act = {action_select_hi, action_select_lo};

// select the fuse or lock byte addressed by the two byte selects
function [7:0] fsel;
	input [1:0] sel;
	input [7:0] flo;
	input [7:0] fhi;
	input [7:0] fext;
	input [7:0] lck;
	begin
		case (sel)
			`PPNVM_SEL_FLO: fsel = flo;
			`PPNVM_SEL_FHI: fsel = fhi;
			`PPNVM_SEL_EXT: fsel = fext;
			default: fsel = lck;
		endcase
	end
endfunction

// ****************************************
// strobe edge detectors
// ****************************************
ppnvm_edge u_ld
(
	.sys_clk(sys_clk),
	.rstn(rstn),
	.sig_in(load_strobe),
	.rise_q(ld_rise),
	.fall_q()
);

ppnvm_edge u_pl
(
	.sys_clk(sys_clk),
	.rstn(rstn),
	.sig_in(page_load_strobe),
	.rise_q(pl_rise),
	.fall_q()
);

// write is active low: its falling edge starts a write
ppnvm_edge u_wr
(
	.sys_clk(sys_clk),
	.rstn(rstn),
	.sig_in(write_n),
	.rise_q(),
	.fall_q(wr_fall)
);

// ****************************************
// loads, page buffers and self-timed writes
// ****************************************
// edge flops lag the pins one cycle; levels are assumed stable around
// the strobe so a one-cycle-late sample sees the same values
always @(posedge sys_clk or negedge rstn)
begin
	if (!rstn)
	begin
		state_q <= ST_IDLE;
		cnt_q <= 32'h0000_0000;
		cmd_q <= `PPNVM_CMD_NOP;
		addr_lo_q <= 8'h00;
		addr_hi_q <= 8'h00;
		dat_lo_q <= 8'h00;
		dat_hi_q <= 8'h00;
		fuse_lo_q <= `PPNVM_FUSE_RST;
		fuse_hi_q <= `PPNVM_FUSE_RST;
		fuse_ext_q <= `PPNVM_FUSE_RST;
		lock_q <= `PPNVM_LOCK_RST;
		pend_q <= 8'h00;
		pend_sel_q <= 2'h0;
		pend_cmd_q <= `PPNVM_CMD_NOP;
		epvld_q <= {PDEPTH{1'b0}};
		fpvld_q <= {FDEPTH{1'b0}};
		ready_busy_q <= 1'b1;
		for (i = 0; i < EDEPTH; i = i + 1)
			eep_q[i] <= 8'hff;
		for (i = 0; i < FDEPTH; i = i + 1)
		begin
			flash_q[i] <= 16'hffff;
			fpbuf_q[i] <= 16'hffff;
		end
		for (i = 0; i < PDEPTH; i = i + 1)
			epbuf_q[i] <= 8'hff;
	end
	else
	begin
		// strobe loads decoded by action select
		if (ld_rise)
		begin
			case (act)
				`PPNVM_ACT_ADDR:
				begin
					if (byte_select_one)
						addr_hi_q <= data_in;
					else
						addr_lo_q <= data_in;
				end
				`PPNVM_ACT_DATA:
				begin
					if (byte_select_one)
						dat_hi_q <= data_in;
					else
						dat_lo_q <= data_in;
				end
				`PPNVM_ACT_CMD:
				begin
					cmd_q <= data_in;
					// nop drops any half-built page
					if (data_in == `PPNVM_CMD_NOP)
					begin
						epvld_q <= {PDEPTH{1'b0}};
						fpvld_q <= {FDEPTH{1'b0}};
					end
				end
				default:
				begin
				end
			endcase
		end
		case (state_q)
			ST_IDLE:
			begin
				// busy blocks new writes, so no restart mid-write
				if (wr_fall)
				begin
					state_q <= ST_BUSY;
					ready_busy_q <= 1'b0;
					cnt_q <= 32'h0000_0000;
					pend_cmd_q <= cmd_q;
					pend_q <= dat_lo_q;
					pend_sel_q <= {byte_select_two, byte_select_one};
				end
			end
			ST_BUSY:
			begin
				if (cnt_q >= WRITE_CYC - 1)
				begin
					state_q <= ST_IDLE;
					ready_busy_q <= 1'b1;
					case (pend_cmd_q)
						`PPNVM_CMD_WR_EEP:
						begin
							// whole page commits at once
							for (i = 0; i < PDEPTH; i = i + 1)
								if (epvld_q[i])
									eep_q[{epage, i[EPAGE_W-1:0]}] <=
										epbuf_q[i];
							epvld_q <= {PDEPTH{1'b0}};
						end
						`PPNVM_CMD_WR_FLASH:
						begin
							for (i = 0; i < FDEPTH; i = i + 1)
								if (fpvld_q[i])
									flash_q[i] <= fpbuf_q[i];
							fpvld_q <= {FDEPTH{1'b0}};
						end
						`PPNVM_CMD_WR_FUSE:
						begin
							// 0 programs, 1 erases
							case (pend_sel_q)
								2'h1: fuse_hi_q <= pend_q;
								2'h2: fuse_ext_q <= pend_q;
								default: fuse_lo_q <= pend_q;
							endcase
						end
						// zeros only stick; ones never unprogram
						`PPNVM_CMD_WR_LOCK: lock_q <= lock_q & pend_q;
						`PPNVM_CMD_ERASE:
						begin
							lock_q <= `PPNVM_LOCK_RST;
							for (i = 0; i < EDEPTH; i = i + 1)
								eep_q[i] <= 8'hff;
							for (i = 0; i < FDEPTH; i = i + 1)
								flash_q[i] <= 16'hffff;
						end
						default:
						begin
						end
					endcase
				end
				else
					cnt_q <= cnt_q + 32'h0000_0001;
			end
			default:
			begin
				state_q <= ST_IDLE;
				ready_busy_q <= 1'b1;
			end
		endcase
		// page latch after the commit: a latch in the commit cycle is kept
		if (pl_rise)
		begin
			if (cmd_q == `PPNVM_CMD_WR_EEP)
			begin
				epbuf_q[eoff] <= dat_lo_q;
				epvld_q[eoff] <= 1'b1;
			end
			else if (cmd_q == `PPNVM_CMD_WR_FLASH)
			begin
				fpbuf_q[faddr] <= {dat_hi_q, dat_lo_q};
				fpvld_q[faddr] <= 1'b1;
			end
		end
	end
end

// ****************************************
// read data select
// ****************************************
// output mux follows the retained command and live byte selects
always @*
begin
	rd_d = 8'hff;
	case (cmd_q)
		`PPNVM_CMD_RD_FLASH:
			rd_d = byte_select_one ? flash_q[faddr][15:8] :
				flash_q[faddr][7:0];
		`PPNVM_CMD_RD_EEP:
			rd_d = eep_q[eaddr];
		`PPNVM_CMD_RD_FUSE:
			rd_d = fsel({byte_select_two, byte_select_one}, fuse_lo_q,
				fuse_hi_q, fuse_ext_q, lock_q);
		`PPNVM_CMD_RD_SIG:
		begin
			if (byte_select_one)
				rd_d = CALIB;
			else if (addr_lo_q == 8'h00)
				rd_d = SIG0;
			else if (addr_lo_q == 8'h01)
				rd_d = SIG1;
			else if (addr_lo_q == `PPNVM_SIG_LAST)
				rd_d = SIG2;
			else
				rd_d = 8'hff;
		end
		default: rd_d = 8'hff;
	endcase
end

// ****************************************
// data bus drive
// ****************************************
// registered so the pin outputs never glitch through the mux
always @(posedge sys_clk or negedge rstn)
begin
	if (!rstn)
	begin
		data_out_q <= 8'h00;
		data_oe_q <= 1'b0;
	end
	else
	begin
		data_oe_q <= ~out_en_n;
		data_out_q <= rd_d;
	end
end

endmodule // ppnvm_port

// ### sim/ppnvm_port_monitor.sv
// ppnvm_port_monitor.sv: checker on the programming port pins
// assumes a bind into ppnvm_port, one clock domain
`timescale 1ns/10ps

module ppnvm_port_monitor
#(
	parameter WRITE_CYC = 100 // self-timed length
)
(
	input wire sys_clk, // system clock
	input wire rstn, // async reset, active low
	input wire write_n, // write pulse
	input wire out_en_n, // output enable
	input wire data_oe_q, // bus drive enable
	input wire ready_busy_q // high ready
);
	// ****
	// checks
	// ****
	localparam int BUSY_MAX = WRITE_CYC + 4;
	int busy_cnt_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// busy length; a restarted write would stretch it
	always @(posedge sys_clk or negedge rstn)
		if (!rstn)
			busy_cnt_q <= 0;
		else
			busy_cnt_q <= ready_busy_q ? 0 : busy_cnt_q + 1;
	property p_oe_off; out_en_n |=> !data_oe_q; endproperty
	a_oe_off: assert property (p_oe_off) else $error("bus driven");
	property p_oe_on; !out_en_n |=> data_oe_q; endproperty
	a_oe_on: assert property (p_oe_on) else $error("bus idle");
	property p_oe_drop; $rose(out_en_n) |=> $fell(data_oe_q); endproperty
	a_oe_drop: assert property (p_oe_drop) else $error("late release");
	property p_busy_start;
		$fell(ready_busy_q) |-> !$past(write_n, 2) || !$past(write_n, 3);
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy uncaused");
	property p_write_go;
		$fell(write_n) && ready_busy_q |-> ##[1:3] !ready_busy_q;
	endproperty
	a_write_go: assert property (p_write_go) else $error("write missed");
	property p_busy_len; $fell(ready_busy_q) |-> !ready_busy_q [*4]; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy short");
	property p_busy_end; $fell(ready_busy_q) |-> ##[1:BUSY_MAX] ready_busy_q; endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy stuck");
	property p_busy_cap; busy_cnt_q <= BUSY_MAX; endproperty
	a_busy_cap: assert property (p_busy_cap) else $error("write restarted");
	c_write: cover property ($fell(ready_busy_q));
	c_read: cover property ($rose(data_oe_q));
	c_busy_wr: cover property (!ready_busy_q && $fell(write_n));
endmodule // ppnvm_port_monitor

bind ppnvm_port ppnvm_port_monitor #(.WRITE_CYC(WRITE_CYC)) ppnvm_port_monitor_inst
(
	.sys_clk(sys_clk),
	.rstn(rstn),
	.write_n(write_n),
	.out_en_n(out_en_n),
	.data_oe_q(data_oe_q),
	.ready_busy_q(ready_busy_q)
);

// ### sim/ppnvm_prog.sv
// ppnvm_prog.sv: external programmer model driving the port pins
// assumes the bench calls its tasks; pins move at falling edges
`timescale 1ns/10ps

module ppnvm_prog
(
	input wire clk, // system clock
	input wire [7:0] dout, // device read data
	input wire doe, // device drives bus
	input wire rdy, // high ready
	output logic ld, // load strobe
	output logic ah, // action select hi
	output logic al, // action select lo
	output logic b1, // byte select one
	output logic b2, // byte select two
	output logic pg, // page latch strobe
	output logic wr_n, // write pulse
	output logic oe_n, // output enable
	output wire [7:0] din // bus as seen by device
);
	// ****
	// pins
	// ****
	logic [7:0] pd = 8'h00;
	// released bus toggles so a stale value never passes
	assign din = doe ? dout : (oe_n ? pd : ~pd);
	initial {ld, ah, al, b1, b2, pg, wr_n, oe_n} = 8'h03;
	// pins held three cycles past the strobe edge
	task load(input [1:0] a, input bs, input [7:0] d);
		@(negedge clk);
		{ah, al} = a;
		b1 = bs;
		pd = d;
		@(negedge clk);
		ld = 1'h1;
		repeat (3) @(negedge clk);
		ld = 1'h0;
	endtask
	task latch();
		@(negedge clk);
		pg = 1'h1;
		repeat (3) @(negedge clk);
		pg = 1'h0;
	endtask
	task wr_go(input s1, input s2);
		@(negedge clk);
		{b1, b2} = {s1, s2};
		wr_n = 1'h0;
		repeat (3) @(negedge clk);
		wr_n = 1'h1;
	endtask
	// bounded wait; busy says whether the device went busy
	task wr_wait(output logic busy);
		busy = (rdy === 1'h0);
		for (int n = 0; n < 400 && rdy !== 1'h1; n++)
			@(negedge clk);
		{b1, b2} = 2'h0;
	endtask
	task rd(input s1, input s2, output logic [7:0] v);
		@(negedge clk);
		{b1, b2} = {s1, s2};
		oe_n = 1'h0;
		repeat (3) @(negedge clk);
		v = dout;
		oe_n = 1'h1;
	endtask
endmodule // ppnvm_prog

// ### sim/ppnvm_port_tb_top.sv
// ppnvm_port_tb_top.sv: self-checking bench for the programming port
// assumes programmer model and checker compiled first
`timescale 1ns/10ps
`include "ppnvm_regs.vh"

module ppnvm_port_tb_top;
	// ****
	// bench
	// ****
	logic sys_clk = 1'h0;
	logic rstn = 1'h0;
	logic ld, ah, al, b1, b2, pg, wr_n, oe_n, doe, rdy, busy;
	logic [7:0] din, dout, v;
	int mismatches = 0;
	int check_count = 0;
	int cyc = 0;
	always #5 sys_clk = ~sys_clk;
	// signature and calibration values are arbitrary
	ppnvm_port #(.WRITE_CYC(8), .SIG0(8'h21), .SIG1(8'h43), .SIG2(8'h65),
		.CALIB(8'h87)) ppnvm_port_inst
	(
		.sys_clk(sys_clk), .rstn(rstn), .load_strobe(ld),
		.action_select_hi(ah), .action_select_lo(al),
		.byte_select_one(b1), .byte_select_two(b2),
		.page_load_strobe(pg), .write_n(wr_n), .out_en_n(oe_n),
		.data_in(din), .data_out_q(dout), .data_oe_q(doe),
		.ready_busy_q(rdy)
	);
	ppnvm_prog ppnvm_prog_inst
	(
		.clk(sys_clk), .dout(dout), .doe(doe), .rdy(rdy), .ld(ld),
		.ah(ah), .al(al), .b1(b1), .b2(b2), .pg(pg), .wr_n(wr_n),
		.oe_n(oe_n), .din(din)
	);
	task chk(input string n, input [7:0] e, input [7:0] g);
		check_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task cmd(input [7:0] d);
		ppnvm_prog_inst.load(`PPNVM_ACT_CMD, 1'h0, d);
	endtask
	task adr(input bs, input [7:0] d);
		ppnvm_prog_inst.load(`PPNVM_ACT_ADDR, bs, d);
	endtask
	task dat(input bs, input [7:0] d);
		ppnvm_prog_inst.load(`PPNVM_ACT_DATA, bs, d);
	endtask
	task wr(input s1, input s2);
		ppnvm_prog_inst.wr_go(s1, s2);
		ppnvm_prog_inst.wr_wait(busy);
		chk("busy", 8'h01, {7'h00, busy});
	endtask
	task rd(input s1, input s2, input [7:0] e, input string n);
		ppnvm_prog_inst.rd(s1, s2, v);
		chk(n, e, v);
		chk("oe", 8'h01, {7'h00, doe});
	endtask
	task t_reset();
		cmd(`PPNVM_CMD_RD_FUSE);
		rd(1'h0, 1'h0, 8'hff, "flo");
		rd(1'h1, 1'h1, 8'hff, "fhi");
		rd(1'h0, 1'h1, 8'hff, "fext");
		rd(1'h1, 1'h0, 8'hff, "lock");
	endtask
	// command loaded once serves all three fuse writes
	task t_fuse();
		cmd(`PPNVM_CMD_WR_FUSE);
		dat(1'h0, 8'ha5);
		wr(1'h0, 1'h0);
		dat(1'h0, 8'h3c);
		wr(1'h1, 1'h0);
		dat(1'h0, 8'h5a);
		wr(1'h0, 1'h1);
		cmd(`PPNVM_CMD_RD_FUSE);
		rd(1'h0, 1'h0, 8'ha5, "flo");
		rd(1'h1, 1'h1, 8'h3c, "fhi");
		rd(1'h0, 1'h1, 8'h5a, "fext");
	endtask
	// extra write pulse while busy; second write may only program
	task t_lock();
		cmd(`PPNVM_CMD_WR_LOCK);
		dat(1'h0, 8'hf0);
		ppnvm_prog_inst.wr_go(1'h0, 1'h0);
		ppnvm_prog_inst.wr_go(1'h0, 1'h0);
		ppnvm_prog_inst.wr_wait(busy);
		chk("busy", 8'h01, {7'h00, busy});
		dat(1'h0, 8'h0f);
		wr(1'h0, 1'h0);
		cmd(`PPNVM_CMD_RD_FUSE);
		rd(1'h1, 1'h0, 8'h00, "lock");
	endtask
	task t_eep();
		cmd(`PPNVM_CMD_WR_EEP);
		adr(1'h1, 8'h00);
		for (int i = 4; i < 8; i++)
		begin
			adr(1'h0, 8'(i));
			dat(1'h0, 8'h10 + 8'(i));
			ppnvm_prog_inst.latch();
		end
		wr(1'h0, 1'h0);
		cmd(`PPNVM_CMD_RD_EEP);
		for (int i = 4; i < 8; i++)
		begin
			adr(1'h0, 8'(i));
			rd(1'h0, 1'h0, 8'h10 + 8'(i), "eep");
		end
	endtask
	task t_flash();
		cmd(`PPNVM_CMD_WR_FLASH);
		adr(1'h0, 8'h05);
		dat(1'h0, 8'h34);
		dat(1'h1, 8'h12);
		ppnvm_prog_inst.latch();
		adr(1'h1, 8'h00);
		wr(1'h0, 1'h0);
		// half-built page dropped by nop must never be programmed
		adr(1'h0, 8'h06);
		dat(1'h0, 8'h77);
		ppnvm_prog_inst.latch();
		cmd(`PPNVM_CMD_NOP);
		cmd(`PPNVM_CMD_WR_FLASH);
		wr(1'h0, 1'h0);
		cmd(`PPNVM_CMD_RD_FLASH);
		adr(1'h1, 8'h00);
		adr(1'h0, 8'h05);
		rd(1'h0, 1'h0, 8'h34, "fl_lo");
		rd(1'h1, 1'h0, 8'h12, "fl_hi");
		adr(1'h0, 8'h06);
		rd(1'h0, 1'h0, 8'hff, "fl_drop");
	endtask
	// erase clears arrays and lock, fuses survive
	task t_erase();
		cmd(`PPNVM_CMD_ERASE);
		wr(1'h0, 1'h0);
		cmd(`PPNVM_CMD_RD_FUSE);
		rd(1'h1, 1'h0, 8'hff, "lock");
		rd(1'h0, 1'h0, 8'ha5, "flo");
		cmd(`PPNVM_CMD_RD_FLASH);
		adr(1'h0, 8'h05);
		rd(1'h1, 1'h0, 8'hff, "fl_hi");
		cmd(`PPNVM_CMD_RD_EEP);
		adr(1'h0, 8'h04);
		rd(1'h0, 1'h0, 8'hff, "eep");
	endtask
	// idle action must leave the address alone
	task t_sig();
		cmd(`PPNVM_CMD_RD_SIG);
		adr(1'h0, 8'h00);
		rd(1'h0, 1'h0, 8'h21, "sig0");
		adr(1'h0, 8'h01);
		rd(1'h0, 1'h0, 8'h43, "sig1");
		adr(1'h0, 8'h02);
		rd(1'h0, 1'h0, 8'h65, "sig2");
		ppnvm_prog_inst.load(`PPNVM_ACT_IDLE, 1'h0, 8'h01);
		rd(1'h0, 1'h0, 8'h65, "sig2");
		adr(1'h0, 8'h03);
		rd(1'h0, 1'h0, 8'hff, "sig3");
		rd(1'h1, 1'h0, 8'h87, "calib");
	endtask
	task end_sim();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(negedge sys_clk);
		rstn = 1'h1;
		t_reset();
		t_fuse();
		t_lock();
		t_eep();
		t_flash();
		t_sig();
		t_erase();
		end_sim();
	end
	// hang guard, well above the roughly five hundred cycles needed
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			end_sim();
		end
	end
endmodule // ppnvm_port_tb_top
